// ===== ocp_cfg.svh
// offsets, field positions, reset values and timing counts of the overcurrent block
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register aperture
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// system clock rate in MHz
`define OCP_CLK_MHZ 100

// register byte offsets inside the block aperture
`define OCP_ADDR_CTRL 8'h00
`define OCP_ADDR_DIAG 8'h04
`define OCP_ADDR_STAT 8'h08
`define OCP_ADDR_GATE 8'h0c

// general_control_reg1 fields
`define OCP_CTRL_TRIP_BIT 0
`define OCP_CTRL_RST 1'h0

// bridge_diag_control_reg fields
`define OCP_DIAG_FILT1_LSB 0
`define OCP_DIAG_FILT2_LSB 2
`define OCP_DIAG_DIR1_BIT 4
`define OCP_DIAG_DIR2_BIT 5
`define OCP_DIAG_LVL1_LSB 8
`define OCP_DIAG_LVL2_LSB 10
`define OCP_DIAG_RST 12'h000

// general_status_reg fields
`define OCP_STAT_ANY_BIT 0
`define OCP_STAT_CH1_BIT 1
`define OCP_STAT_CH2_BIT 2
`define OCP_STAT_GERR_BIT 3

// overcurrent filter times in ns, one per filter-select code
`define OCP_FILT_T0_NS 1000
`define OCP_FILT_T1_NS 2000
`define OCP_FILT_T2_NS 5000
`define OCP_FILT_T3_NS 10000

// filter times in clock cycles, rounded up, at least one
`define OCP_NS2CYC(t) ((((t) * `OCP_CLK_MHZ + 999) / 1000) < 1 ? 1 : (((t) * `OCP_CLK_MHZ + 999) / 1000))
`define OCP_FILT_C0 `OCP_NS2CYC(`OCP_FILT_T0_NS)
`define OCP_FILT_C1 `OCP_NS2CYC(`OCP_FILT_T1_NS)
`define OCP_FILT_C2 `OCP_NS2CYC(`OCP_FILT_T2_NS)
`define OCP_FILT_C3 `OCP_NS2CYC(`OCP_FILT_T3_NS)

`endif

// ===== ocp_pkg.sv
// types shared by the overcurrent block
// assumes nothing of its surroundings
package ocp_pkg;

   // sensing direction per channel
   typedef enum logic {
      DIR_UNI = 1'b0,
      DIR_BI = 1'b1
   } sense_dir_t;

   // qualifier state, one-hot
   typedef enum logic [1:0] {
      FLT_CLEAR = 2'b01,
      FLT_SET = 2'b10
   } filt_state_t;

   typedef logic [1:0] level_code_t;
   typedef logic [1:0] filt_code_t;

endpackage

// ===== ocp_channel.sv
// one sense channel: threshold compare, two-stage resample, time filter
// assumes amp_code is a straight binary sample of the amplifier output, full scale = supply
`include "ocp_cfg.svh"

module ocp_channel
   import ocp_pkg::*;
#(
   parameter int W = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // amplifier sample and settings
   input wire logic [W-1:0] amp_code,
   input wire sense_dir_t dir_sel,
   input wire level_code_t level_sel,
   input wire filt_code_t filt_sel,
   // filtered overcurrent condition
   output logic qual
);

   localparam int FS = 1 << W;
   localparam logic [W:0] HALF = (W+1)'(FS / 2);
   localparam int CW = 16;

   logic [W:0] uni_lvl;
   logic [W:0] bi_hw;
   logic cmp_raw;
   logic cmp_s1_ff;
   logic cmp_s2_ff;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] limit;
   filt_state_t state_ff;

   always_comb begin
      case (level_sel)
         2'h0: uni_lvl = HALF;
         2'h1: uni_lvl = HALF + (W+1)'(FS / 10);
         2'h2: uni_lvl = HALF + (W+1)'(2 * FS / 10);
         default: uni_lvl = HALF + (W+1)'(3 * FS / 10);
      endcase
   end

   always_comb begin
      case (level_sel)
         2'h0: bi_hw = (W+1)'(2 * FS / 20);
         2'h1: bi_hw = (W+1)'(4 * FS / 20);
         2'h2: bi_hw = (W+1)'(5 * FS / 20);
         default: bi_hw = (W+1)'(6 * FS / 20);
      endcase
   end

   always_comb begin
      if (dir_sel == DIR_UNI) begin
         cmp_raw = {1'b0, amp_code} > uni_lvl;
      end else begin
         cmp_raw = ({1'b0, amp_code} > HALF + bi_hw) || ({1'b0, amp_code} < HALF - bi_hw);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_s1_ff <= 1'b0;
         cmp_s2_ff <= 1'b0;
      end else begin
         cmp_s1_ff <= cmp_raw;
         cmp_s2_ff <= cmp_s1_ff;
      end
   end

   // filter length picked per channel
   always_comb begin
      case (filt_sel)
         2'h0: limit = CW'(`OCP_FILT_C0);
         2'h1: limit = CW'(`OCP_FILT_C1);
         2'h2: limit = CW'(`OCP_FILT_C2);
         default: limit = CW'(`OCP_FILT_C3);
      endcase
   end

   // qualify presence for the filter time
   // drop only after absence longer than it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= FLT_CLEAR;
         cnt_ff <= '0;
      end else begin
         case (state_ff)
            FLT_CLEAR: begin
               if (!cmp_s2_ff) begin
                  cnt_ff <= '0;
               end else if (cnt_ff >= limit - CW'(1)) begin
                  state_ff <= FLT_SET;
                  cnt_ff <= '0;
               end else begin
                  cnt_ff <= cnt_ff + CW'(1);
               end
            end
            FLT_SET: begin
               if (cmp_s2_ff) begin
                  cnt_ff <= '0;
               end else if (cnt_ff >= limit) begin
                  state_ff <= FLT_CLEAR; // absent for limit+1 cycles
                  cnt_ff <= '0;
               end else begin
                  cnt_ff <= cnt_ff + CW'(1);
               end
            end
            default: begin
               state_ff <= FLT_CLEAR;
               cnt_ff <= '0;
            end
         endcase
      end
   end

   assign qual = (state_ff == FLT_SET);

endmodule // ocp_channel

// ===== overcurrent_protection_logic.sv
// overcurrent supervision for two sense channels with an AHB-Lite register slave
// assumes synchronous sampled amplifier codes and a single 100 MHz clock
//
// How it works
// - unidirectional: trip above half supply plus 0..3 tenths by code.
// - bidirectional: trip outside half supply plus/minus 2,4,5,6 twentieths.
// - trip disabled: detection sets flags and global error, gates untouched.
// - trip disabled: flags self-clear after absence longer than filter time.
// - trip enabled: detection sets flags, global error, forces all gates off.
// - gates released only by status clear or trip enable written zero.
// - trip enabled: flags held until condition gone and status cleared.
// - per-channel selectable filter qualifies the compare result.
// - direction bit 0 uses level table, 1 uses window table.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`include "ocp_cfg.svh"

module overcurrent_protection_logic
   import ocp_pkg::*;
#(
   parameter int W = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // amplifier samples
   input wire logic [W-1:0] amp_output_pin_ch1,
   input wire logic [W-1:0] amp_output_pin_ch2,
   // status and driver control
   output logic overcurrent_any_flag,
   output logic overcurrent_ch1_flag,
   output logic overcurrent_ch2_flag,
   output logic global_error_flag,
   output logic gate_force_off
);

   logic trip_en_ff;
   logic [11:0] diag_ff;
   logic ch1_ff;
   logic ch2_ff;
   logic any_ff;
   logic gerr_ff;
   logic gate_off_ff;
   logic qual1;
   logic qual2;
   logic qual1_d_ff;
   logic qual2_d_ff;
   logic det1;
   logic det2;
   logic det_any;
   logic nxt_ch1;
   logic nxt_ch2;
   logic aphase;
   logic dvalid_ff;
   logic dwrite_ff;
   logic [7:0] daddr_ff;
   logic [31:0] hrdata_ff;
   logic wr_ctrl;
   logic wr_diag;
   logic wr_stat;
   logic trip_off_wr;
   logic [31:0] rd_mux;

   // each channel has its own instance of the parameterised filter
   ocp_channel #(.W(W)) u_ch1 (
      .hclk(hclk),
      .hresetn(hresetn),
      .amp_code(amp_output_pin_ch1),
      .dir_sel(sense_dir_t'(diag_ff[`OCP_DIAG_DIR1_BIT])),
      .level_sel(diag_ff[`OCP_DIAG_LVL1_LSB +: 2]),
      .filt_sel(diag_ff[`OCP_DIAG_FILT1_LSB +: 2]),
      .qual(qual1)
   );

   ocp_channel #(.W(W)) u_ch2 (
      .hclk(hclk),
      .hresetn(hresetn),
      .amp_code(amp_output_pin_ch2),
      .dir_sel(sense_dir_t'(diag_ff[`OCP_DIAG_DIR2_BIT])),
      .level_sel(diag_ff[`OCP_DIAG_LVL2_LSB +: 2]),
      .filt_sel(diag_ff[`OCP_DIAG_FILT2_LSB +: 2]),
      .qual(qual2)
   );

   // address phase taken when selected, non-idle and bus ready
   assign aphase = hsel && htrans[1] && hready;

   // data-phase strobes; upper address bits are not decoded
   assign wr_ctrl = dvalid_ff && dwrite_ff && (daddr_ff == `OCP_ADDR_CTRL);
   assign wr_diag = dvalid_ff && dwrite_ff && (daddr_ff == `OCP_ADDR_DIAG);
   assign wr_stat = dvalid_ff && dwrite_ff && (daddr_ff == `OCP_ADDR_STAT);
   assign trip_off_wr = wr_ctrl && !hwdata[`OCP_CTRL_TRIP_BIT];

   // capture of the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dvalid_ff <= 1'b0;
         dwrite_ff <= 1'b0;
         daddr_ff <= 8'h00;
      end else begin
         dvalid_ff <= aphase;
         if (aphase) begin
            dwrite_ff <= hwrite;
            daddr_ff <= haddr[7:0];
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         `OCP_ADDR_CTRL: rd_mux[`OCP_CTRL_TRIP_BIT] = trip_en_ff;
         `OCP_ADDR_DIAG: rd_mux[11:0] = diag_ff;
         `OCP_ADDR_STAT: begin
            rd_mux[`OCP_STAT_ANY_BIT] = any_ff;
            rd_mux[`OCP_STAT_CH1_BIT] = ch1_ff;
            rd_mux[`OCP_STAT_CH2_BIT] = ch2_ff;
            rd_mux[`OCP_STAT_GERR_BIT] = gerr_ff;
         end
         `OCP_ADDR_GATE: rd_mux[0] = gate_off_ff;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data sampled in the address phase, so no wait states needed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (aphase && !hwrite) begin
         hrdata_ff <= rd_mux;
      end
   end

   // configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_en_ff <= `OCP_CTRL_RST;
         diag_ff <= `OCP_DIAG_RST;
      end else begin
         if (wr_ctrl) begin
            trip_en_ff <= hwdata[`OCP_CTRL_TRIP_BIT];
         end
         if (wr_diag) begin
            diag_ff <= hwdata[11:0];
         end
      end
   end

   // rising edge of the filtered condition is the detection event
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qual1_d_ff <= 1'b0;
         qual2_d_ff <= 1'b0;
      end else begin
         qual1_d_ff <= qual1;
         qual2_d_ff <= qual2;
      end
   end

   assign det1 = qual1 && !qual1_d_ff;
   assign det2 = qual2 && !qual2_d_ff;
   assign det_any = det1 || det2;

   // channel flag next values
   always_comb begin
      if (!trip_en_ff) begin
         nxt_ch1 = qual1;
         nxt_ch2 = qual2;
      end else begin
         nxt_ch1 = qual1 || (ch1_ff && !wr_stat);
         nxt_ch2 = qual2 || (ch2_ff && !wr_stat);
      end
   end

   // status flags, condition wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ch1_ff <= 1'b0;
         ch2_ff <= 1'b0;
         any_ff <= 1'b0;
      end else begin
         ch1_ff <= nxt_ch1;
         ch2_ff <= nxt_ch2;
         any_ff <= nxt_ch1 || nxt_ch2;
      end
   end

   // global error set on any detection; set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gerr_ff <= 1'b0;
      end else if (det_any) begin
         gerr_ff <= 1'b1;
      end else if (wr_stat) begin
         gerr_ff <= 1'b0;
      end
   end

   // force every driver off on detection while trip is enabled
   // release by status clear or trip enable zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_off_ff <= 1'b0;
      end else if (trip_en_ff && det_any) begin
         gate_off_ff <= 1'b1;
      end else if (wr_stat || trip_off_wr) begin
         gate_off_ff <= 1'b0;
      end
   end

   // bus answer: always ready, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_ff;
   assign overcurrent_any_flag = any_ff;
   assign overcurrent_ch1_flag = ch1_ff;
   assign overcurrent_ch2_flag = ch2_ff;
   assign global_error_flag = gerr_ff;
   assign gate_force_off = gate_off_ff;

endmodule // overcurrent_protection_logic

// ===== ocp_properties.sv
// port checker of the overcurrent block, bound to its top module
// assumes hclk rising edge, active-low hresetn, hready tied to hreadyout
module ocp_port_checker (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // status and drivers
   input wire logic overcurrent_any_flag,
   input wire logic overcurrent_ch1_flag,
   input wire logic overcurrent_ch2_flag,
   input wire logic global_error_flag,
   input wire logic gate_force_off
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // address phases taken by the slave
   logic take;
   assign take = hsel && htrans[1] && hreadyout;
   property p_any_or;
      overcurrent_any_flag == (overcurrent_ch1_flag || overcurrent_ch2_flag);
   endproperty
   a_any_or: assert property (p_any_or) else $error("combined flag wrong");
   property p_err_on_flag;
      $rose(overcurrent_ch1_flag || overcurrent_ch2_flag) |-> global_error_flag;
   endproperty
   a_err_on_flag: assert property (p_err_on_flag) else $error("no global error");
   property p_gate_err;
      gate_force_off |-> global_error_flag;
   endproperty
   a_gate_err: assert property (p_gate_err) else $error("gate off without error");
   property p_gate_cause;
      $rose(gate_force_off) |-> overcurrent_any_flag;
   endproperty
   a_gate_cause: assert property (p_gate_cause) else $error("gate off without flag");
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
   property p_ch1_hold;
      $rose(overcurrent_ch1_flag) |=> overcurrent_ch1_flag [*8];
   endproperty
   a_ch1_hold: assert property (p_ch1_hold) else $error("ch1 flag dropped early");
   property p_ch2_quiet;
      $fell(overcurrent_ch2_flag) |=> !overcurrent_ch2_flag [*8];
   endproperty
   a_ch2_quiet: assert property (p_ch2_quiet) else $error("ch2 flag back early");
   property p_unmapped;
      take && !hwrite && haddr[7:0] >= 8'h10 |=> hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_stat_clear;
      take && hwrite && haddr[7:0] == 8'h08 |-> ##2 !global_error_flag && !gate_force_off;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status clear ignored");
   // main scenarios reached
   c_trip: cover property ($rose(gate_force_off));
   c_ch2: cover property ($rose(overcurrent_ch2_flag));
   c_clear: cover property ($fell(global_error_flag));
endmodule // ocp_port_checker

bind overcurrent_protection_logic ocp_port_checker u_ocp_port_checker (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hreadyout, .hrdata, .hresp, .overcurrent_any_flag, .overcurrent_ch1_flag,
   .overcurrent_ch2_flag, .global_error_flag, .gate_force_off);

// ===== ahb_master_model.sv
// ahb-lite master standing in for the microcontroller
// assumes one slave whose hreadyout is the bus hready
module ahb_master_model (
   // clock
   input wire logic hclk,
   // slave answer
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   // request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   logic [31:0] rd_dat;
   event rd_ev;
   // idle bus from time zero
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   // single word, each phase held until hready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dat = hrdata;
      if (!w) -> rd_ev;
   endtask
endmodule // ahb_master_model

// ===== overcurrent_protection_logic_tb.sv
// self-checking bench of the overcurrent block
// assumes the master model and the bound port checker
`include "ocp_cfg.svh"
`define CMP(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t %h %h", $time, g, e); end end
module overcurrent_protection_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, gate_force_off, global_error_flag;
   logic overcurrent_any_flag, overcurrent_ch1_flag, overcurrent_ch2_flag;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, e_now;
   logic [9:0] amp_output_pin_ch1 = 10'h200;
   logic [9:0] amp_output_pin_ch2 = 10'h200;
   logic [31:0] exp_q[$];
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int thr[4] = '{0, 102, 204, 307};
   int hw[4] = '{102, 204, 256, 307};
   int regs[5] = '{0, 4, 8, 12, 16};
   always #5 hclk = ~hclk;
   overcurrent_protection_logic u_overcurrent_protection_logic (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .amp_output_pin_ch1,
      .amp_output_pin_ch2, .overcurrent_any_flag, .overcurrent_ch1_flag, .overcurrent_ch2_flag,
      .global_error_flag, .gate_force_off);
   ahb_master_model u_ahb_master_model (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata);
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // note the expected word, then read it
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      u_ahb_master_model.xfer(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_ahb_master_model.xfer(1'b1, a, d);
   endtask
   // new amplifier samples, then settle for n cycles of filter time
   task automatic amp(input int a, input int b, input int n);
      @(posedge hclk);
      amp_output_pin_ch1 <= a[9:0];
      amp_output_pin_ch2 <= b[9:0];
      repeat (n) @(posedge hclk);
   endtask
   // oldest note against each completed read
   always @(u_ahb_master_model.rd_ev) begin
      e_now = exp_q.pop_front();
      `CMP(hrdata, e_now)
      // status pins must agree with the expected register word
      if (u_ahb_master_model.haddr[7:0] == `OCP_ADDR_STAT)
         `CMP({global_error_flag, overcurrent_ch2_flag, overcurrent_ch1_flag, overcurrent_any_flag}, e_now[3:0])
      if (u_ahb_master_model.haddr[7:0] == `OCP_ADDR_GATE)
         `CMP(gate_force_off, e_now[0])
   end
   // cut a hang short, run needs about 1500 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(63));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (regs[i]) chk(regs[i][7:0], 32'h0);
      // each level code, ch1 level table, ch2 window table, trip off
      for (int l = 0; l < 4; l++) begin
         wr(`OCP_ADDR_DIAG, (l << 8) | (l << 10) | 32'h20);
         wr(`OCP_ADDR_STAT, 32'h0);
         // odd codes leave the window on the high side, even codes on the low side
         amp(513 + thr[l], (l % 2) ? 513 + hw[l] : 511 - hw[l], 50);
         chk(`OCP_ADDR_STAT, 32'h0);
         repeat (70) @(posedge hclk);
         chk(`OCP_ADDR_STAT, 32'hf);
         chk(`OCP_ADDR_GATE, 32'h0);
         amp(512 + thr[l] - $urandom_range(50), 512 - hw[l] + $urandom_range(50), 120);
         chk(`OCP_ADDR_STAT, 32'h8);
      end
      // trip on: gates forced off, flags held until the host clears
      amp(512, 512, 1);
      wr(`OCP_ADDR_DIAG, 32'h0);
      wr(`OCP_ADDR_CTRL, 32'h1);
      chk(`OCP_ADDR_CTRL, 32'h1);
      amp(513, 512, 120);
      chk(`OCP_ADDR_STAT, 32'hb);
      chk(`OCP_ADDR_GATE, 32'h1);
      amp(512, 512, 120);
      chk(`OCP_ADDR_STAT, 32'hb);
      wr(`OCP_ADDR_STAT, 32'h0);
      chk(`OCP_ADDR_STAT, 32'h0);
      chk(`OCP_ADDR_GATE, 32'h0);
      amp(513, 512, 120);
      wr(`OCP_ADDR_CTRL, 32'h0);
      chk(`OCP_ADDR_GATE, 32'h0);
      tally_and_finish();
   end
endmodule // overcurrent_protection_logic_tb
